// [rtl/irq_unit.sv]
`timescale 1ns/1ps
module irq_unit
    import irq_unit_pkg::*;
(
    input  wire logic                              sys_clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              ext_irq_high_n_i,
    input  wire logic                              ext_irq_low_n_i,
    input  wire logic                              serial_irq_i,
    input  wire logic                              timer1_overflow_irq_i,
    input  wire logic                              timer2_overflow_irq_i,
    input  wire logic                              interval_tick_irq_i,
    input  wire logic                              boundary_i,
    input  wire logic                              exchange_op_i,
    input  wire logic [irq_unit_pkg::mask_width-1:0] acc_data_i,
    input  wire irq_unit_pkg::clear_op_type        clear_op_i,
    input  wire logic [irq_unit_pkg::num_sources-1:0] clear_field_i,
    input  wire logic                              return_from_service_i,
    output logic [irq_unit_pkg::mask_width-1:0]    mask_read_o,
    output logic                                   master_interrupt_enable_o,
    output logic [irq_unit_pkg::num_sources-1:0]   request_latch_o,
    output logic                                   ack_busy_o,
    output logic                                   push_pc_flags_o,
    output logic                                   load_vector_o,
    output logic [irq_unit_pkg::vec_width-1:0]     vector_o,
    output logic                                   set_status_flag_o,
    output logic                                   restore_pc_flags_o
);
    import irq_unit_pkg::*;

    typedef enum logic [1:0] {
        st_idle,
        st_ack1,
        st_ack2
    } ack_state_type;

    ack_state_type state;
    ack_state_type next_state;

    logic [5:0]  latch;
    logic [3:0]  mask;
    logic        master;
    logic [5:0]  set_req;
    logic [5:0]  enabled;
    logic [5:0]  winner;
    logic [5:0]  keep;
    logic        accept;
    logic [11:0] win_vec;
    logic        high_fall;
    logic        low_fall;

    logic        at_boundary;
    logic        any_enabled;
    logic [5:0]  accept_clear;
    logic        cmd_clear;
    logic        cmd_enable;
    logic        cmd_disable;
    logic [5:0]  next_latch;
    logic [3:0]  next_mask;
    logic [3:0]  next_mask_read;
    logic        next_master;
    logic        next_ack_busy;
    logic        next_push;
    logic        next_load;
    logic        next_set_status;
    logic        next_restore;
    logic [11:0] next_vector;

    pin_fall_detect high_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (ext_irq_high_n_i),
        .fall_o    (high_fall)
    );

    pin_fall_detect low_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (ext_irq_low_n_i),
        .fall_o    (low_fall)
    );

    // priority pick, highest rank wins
    function automatic logic [5:0] pick(input logic [5:0] req);
        logic [5:0] one;
        one = 6'h00;
        for (int i = 5; i >= 0; i--) begin
            if (req[i] && one == 6'h00) begin
                one[i] = 1'b1;
            end
        end
        return one;
    endfunction

    // vector for a one-hot winner
    function automatic logic [11:0] vec_of(input logic [5:0] sel);
        logic [11:0] v;
        v = vec_ext_low;
        if (sel[src_ext_high]) v = vec_ext_high;
        else if (sel[src_serial]) v = vec_serial;
        else if (sel[src_timer1]) v = vec_timer1;
        else if (sel[src_timer2]) v = vec_timer2;
        else if (sel[src_tick]) v = vec_tick;
        return v;
    endfunction

    // source requests, external ones on falling pin edges
    assign set_req[src_ext_high] = high_fall;
    assign set_req[src_serial]   = serial_irq_i;
    assign set_req[src_timer1]   = timer1_overflow_irq_i;
    assign set_req[src_timer2]   = timer2_overflow_irq_i;
    assign set_req[src_tick]     = interval_tick_irq_i;
    assign set_req[src_ext_low]  = low_fall;

    // enable gating
    assign enabled[src_ext_high] = latch[src_ext_high] & master;
    assign enabled[src_serial]   = latch[src_serial] & master & mask[mask_serial];
    assign enabled[src_timer1]   = latch[src_timer1] & master & mask[mask_timer1];
    assign enabled[src_timer2]   = latch[src_timer2] & master & mask[mask_timer2];
    assign enabled[src_tick]     = latch[src_tick] & master & mask[mask_timer2];
    assign enabled[src_ext_low]  = latch[src_ext_low] & master & mask[mask_ext_low];

    assign winner  = pick(enabled);
    assign win_vec = vec_of(winner);
    // acceptance only at an instruction boundary while idle
    // boundary_i is ignored while the two acknowledge cycles run
    assign at_boundary     = (state == st_idle) && boundary_i;
    assign any_enabled     = (winner != 6'h00);
    assign accept          = at_boundary && any_enabled;
    assign accept_clear    = accept ? winner : 6'h00;

    // latch-clear command decode
    assign cmd_clear       = (clear_op_i != clr_none);
    assign cmd_enable      = (clear_op_i == clr_enable);
    assign cmd_disable     = (clear_op_i == clr_disable);
    // clear field: 0 clears, 1 keeps
    assign keep            = cmd_clear ? clear_field_i : 6'h3f;

    // only requests set; clears by instruction or acceptance; set wins
    assign next_latch      = (latch & keep & ~accept_clear) | set_req;

    // old mask handed back to the accumulator on exchange
    assign next_mask       = exchange_op_i ? acc_data_i : mask;
    assign next_mask_read  = exchange_op_i ? mask : mask_read_o;

    // sequencer strobes; only pc and flags handled
    assign next_ack_busy   = accept || (state == st_ack1);
    assign next_push       = accept;
    assign next_load       = (state == st_ack1);
    assign next_set_status = (state == st_ack1);
    assign next_restore    = return_from_service_i;
    // vector held until the next acceptance
    assign next_vector     = accept ? win_vec : vector_o;

    // two-cycle acknowledge sequencer
    always_comb begin
        case (state)
            st_idle: next_state = accept ? st_ack1 : st_idle;
            st_ack1: next_state = st_ack2;
            st_ack2: next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    // acceptance outranks return and enable, which outrank disable
    always_comb begin
        if (accept) begin
            next_master = 1'b0;
        end else if (return_from_service_i || cmd_enable) begin
            next_master = 1'b1;
        end else if (cmd_disable) begin
            next_master = 1'b0;
        end else begin
            next_master = master;
        end
    end

    // registered state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // latch, mask and master enable registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            latch <= latch_reset;
        end else begin
            latch <= next_latch;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mask <= mask_reset;
        end else begin
            mask <= next_mask;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            master <= master_reset;
        end else begin
            master <= next_master;
        end
    end

    // registered outputs, each straight from its own flip-flop
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mask_read_o <= mask_reset;
        end else begin
            mask_read_o <= next_mask_read;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            master_interrupt_enable_o <= master_reset;
        end else begin
            master_interrupt_enable_o <= master;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            request_latch_o <= latch_reset;
        end else begin
            request_latch_o <= latch;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_busy_o <= 1'b0;
        end else begin
            ack_busy_o <= next_ack_busy;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            push_pc_flags_o <= 1'b0;
        end else begin
            push_pc_flags_o <= next_push;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_vector_o <= 1'b0;
        end else begin
            load_vector_o <= next_load;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            set_status_flag_o <= 1'b0;
        end else begin
            set_status_flag_o <= next_set_status;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            vector_o <= vec_reset;
        end else begin
            vector_o <= next_vector;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            restore_pc_flags_o <= 1'b0;
        end else begin
            restore_pc_flags_o <= next_restore;
        end
    end
endmodule // irq_unit

// [rtl/irq_unit_pkg.sv]
package irq_unit_pkg;

    localparam int unsigned num_sources = 6;
    localparam int unsigned mask_width  = 4;
    localparam int unsigned vec_width   = 12;
    localparam int unsigned ack_cycles  = 2;

    // latch index of each source
    localparam int unsigned src_ext_high = 5;
    localparam int unsigned src_serial   = 4;
    localparam int unsigned src_timer1   = 3;
    localparam int unsigned src_timer2   = 2;
    localparam int unsigned src_tick     = 1;
    localparam int unsigned src_ext_low  = 0;

    // mask bit positions
    localparam int unsigned mask_serial  = 3;
    localparam int unsigned mask_timer1  = 2;
    localparam int unsigned mask_timer2  = 1;
    localparam int unsigned mask_ext_low = 0;

    // entry addresses
    localparam logic [11:0] vec_ext_high = 12'h002;
    localparam logic [11:0] vec_serial   = 12'h004;
    localparam logic [11:0] vec_timer1   = 12'h006;
    localparam logic [11:0] vec_timer2   = 12'h008;
    localparam logic [11:0] vec_tick     = 12'h00a;
    localparam logic [11:0] vec_ext_low  = 12'h00c;

    // reset values
    localparam logic [3:0] mask_reset   = 4'h0;
    localparam logic [5:0] latch_reset  = 6'h00;
    localparam logic       master_reset = 1'b0;
    localparam logic [11:0] vec_reset   = 12'h000;

    // latch-clear instruction kinds
    typedef enum logic [1:0] {
        clr_none,
        clr_only,
        clr_enable,
        clr_disable
    } clear_op_type;

endpackage

// [rtl/pin_fall_detect.sv]
`timescale 1ns/1ps
module pin_fall_detect (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      fall_o
);
    logic sync1;
    logic sync2;
    logic last;

    // two-stage synchroniser, then edge compare on the second stage only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            last  <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
            last  <= sync2;
            fall_o <= last & ~sync2;
        end
    end
endmodule // pin_fall_detect

// [tb/irq_unit_props.sv]
`timescale 1ns/1ps
module irq_unit_props
    import irq_unit_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        serial_irq_i,
    input wire logic        boundary_i,
    input wire logic        return_from_service_i,
    input wire logic [3:0]  mask_read_o,
    input wire logic        master_interrupt_enable_o,
    input wire logic [5:0]  request_latch_o,
    input wire logic        ack_busy_o,
    input wire logic        push_pc_flags_o,
    input wire logic        load_vector_o,
    input wire logic [11:0] vector_o,
    input wire logic        set_status_flag_o,
    input wire logic        restore_pc_flags_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    ack_steps_a: assert property (push_pc_flags_o |=> load_vector_o && set_status_flag_o)
        else $error("load step missing after push");
    ack_len_a: assert property ($rose(ack_busy_o) |-> ack_busy_o ##1 ack_busy_o ##1 !ack_busy_o)
        else $error("acknowledge not two cycles");
    master_off_a: assert property (push_pc_flags_o |=> !master_interrupt_enable_o)
        else $error("master enable kept after accept");
    master_need_a: assert property (push_pc_flags_o |-> master_interrupt_enable_o && $past(boundary_i))
        else $error("accept without master or boundary");
    vector_legal_a: assert property (load_vector_o |-> vector_o inside {12'h002, 12'h004, 12'h006, 12'h008, 12'h00a, 12'h00c})
        else $error("illegal vector");
    latch_cause_a: assert property ($rose(request_latch_o[src_serial]) |-> $past(serial_irq_i) || $past(serial_irq_i, 2))
        else $error("latch set without request");
    pc_restore_a: assert property (return_from_service_i |=> restore_pc_flags_o)
        else $error("no restore after return");
    reset_state_a: assert property (disable iff (1'b0) rst_i ##1 rst_i |-> request_latch_o == 6'h00 && mask_read_o == 4'h0 && !master_interrupt_enable_o)
        else $error("reset state wrong");
    cover property (push_pc_flags_o && vector_o == vec_ext_high);
    cover property (push_pc_flags_o && vector_o == vec_ext_low);
    cover property (restore_pc_flags_o);
endmodule // irq_unit_props
bind irq_unit irq_unit_props u_irq_unit_props (.*);

// [tb/cpu_seq_model.sv]
`timescale 1ns/1ps
module cpu_seq_model (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    input  wire logic ack_busy_i,
    input  wire logic load_vector_i,
    output logic      boundary_o,
    output logic      return_o
);
    int wait_cnt = 0;
    initial begin
        boundary_o = 0;
        return_o = 0;
    end
    // instruction ends every cycle, or every other one when slow, but never while ack_busy_i is high
    always @(negedge sys_clk_i) begin
        boundary_o <= !rst_i && !ack_busy_i && (!slow_i || !boundary_o);
        return_o <= (wait_cnt == 1);
        if (load_vector_i) wait_cnt <= 4;
        else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    end
endmodule // cpu_seq_model

// [tb/tb_irq_unit.sv]
`timescale 1ns/1ps
`define CHK(a,b) compares++; if ((a) !== (b)) begin num_errors++; $display("unexpected t=%0t %h %h", $time, a, b); end
module tb_irq_unit;
    import irq_unit_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, ext_irq_high_n_i = 1, ext_irq_low_n_i = 1, slow = 0;
    logic serial_irq_i = 0, timer1_overflow_irq_i = 0, timer2_overflow_irq_i = 0, interval_tick_irq_i = 0;
    logic boundary_i, exchange_op_i = 0, return_from_service_i;
    logic [3:0] acc_data_i = 4'h0, mask_read_o, m = 4'h0;
    clear_op_type clear_op_i = clr_none;
    logic [5:0] clear_field_i = 6'h3f, request_latch_o, pend, f, en;
    logic master_interrupt_enable_o, ack_busy_o, push_pc_flags_o, load_vector_o, set_status_flag_o, restore_pc_flags_o;
    logic [11:0] vector_o;
    logic [11:0] vt [6] = '{vec_ext_low, vec_tick, vec_timer2, vec_timer1, vec_serial, vec_ext_high};
    int mb [6] = '{0, 1, 1, 2, 3, 0};
    int num_errors = 0, compares = 0, cyc = 0, r, w;
    irq_unit u_irq_unit (.*);
    cpu_seq_model u_cpu_seq_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow), .ack_busy_i(ack_busy_o),
        .load_vector_i(load_vector_o), .boundary_o(boundary_i), .return_o(return_from_service_i));
    task automatic op(clear_op_type k, logic [5:0] fld);
        clear_op_i = k;
        clear_field_i = fld;
        @(negedge sys_clk_i);
        clear_op_i = clr_none;
        clear_field_i = 6'h3f;
        repeat (2) @(negedge sys_clk_i);
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'he442c763));
        repeat (2) @(negedge sys_clk_i);
        rst_i = 0;
        repeat (3) @(negedge sys_clk_i);
        for (r = 0; r < 24; r++) begin
            pend = 6'($urandom);
            acc_data_i = 4'($urandom);
            slow = r[0];
            {serial_irq_i, timer1_overflow_irq_i, timer2_overflow_irq_i, interval_tick_irq_i} = pend[4:1];
            ext_irq_high_n_i = ~pend[5];
            ext_irq_low_n_i = ~pend[0];
            exchange_op_i = 1;
            @(negedge sys_clk_i);
            {serial_irq_i, timer1_overflow_irq_i, timer2_overflow_irq_i, interval_tick_irq_i} = 4'h0;
            exchange_op_i = 0;
            `CHK(mask_read_o, m)
            m = acc_data_i;
            repeat (3) @(negedge sys_clk_i);
            ext_irq_high_n_i = 1;
            ext_irq_low_n_i = 1;
            repeat (5) @(negedge sys_clk_i);
            `CHK(request_latch_o, pend)
            op(clr_enable, 6'h3f);
            for (w = 0; w < 6; w++) en[w] = pend[w] && (w == 5 || m[mb[w]]);
            while (en != 6'h00) begin
                w = 5;
                while (!en[w]) w--;
                repeat (40) begin
                    if (load_vector_o === 1'b1) break;
                    @(negedge sys_clk_i);
                end
                `CHK(load_vector_o, 1'b1)
                `CHK(set_status_flag_o, 1'b1)
                `CHK(vector_o, vt[w])
                @(negedge sys_clk_i);
                en[w] = 0;
                pend[w] = 0;
            end
            repeat (6) @(negedge sys_clk_i);
            `CHK(request_latch_o, pend)
            f = 6'($urandom);
            op(clr_only, f);
            `CHK(request_latch_o, pend & f)
            op(clr_disable, 6'h00);
            `CHK({master_interrupt_enable_o, request_latch_o}, 7'h00)
            $display("round %0d done", r);
        end
        give_verdict();
    end
endmodule // tb_irq_unit
